// file: hdl/pcc_core.sv
/*
  Primary core clock generator control: oscillator control and switch sequencing,
  clock divider register, PLL feedback and output dividers, fast RC trim, all on
  an AXI4-Lite slave. Assumes the clock mux, PLL and fail-safe monitor sit outside;
  their status pins are asynchronous and are synchronised here.
*/
// Our own choices: the address map and the AXI4-Lite slave port.
////////////////////////////////////////////////////////////////////////////////
// What this block does
// [R01] PLL settled flag reads 1 on lock or timer expiry while a PLL source runs, else 0.
// [R02] Clock-fail flag sets when the fail-safe monitor reports a failure.
// [R03] Writing 1 to the fail flag acts as a real failure and traps.
// [R04] Switch request moves to the next source and self-clears when done.
// [R05] Oscillator control writes take effect only after the unlock sequence.
// [R06] Software passes through plain fast RC between the two PLL sources.
// [R07] With recover-on-irq set, an interrupt clears the ratio-reduction enable.
// [R08] Reduction field divides the processor clock by two to its value.
// [R09] Enable clear forces a 1:1 processor-to-peripheral ratio.
// [R10] Reduction field writes are ignored while the enable is set.
// [R11] Setting the enable is ignored while the reduction field is zero.
// [R12] Fast RC postscaler divides by powers of two, 111 divides by 256.
// [R13] PLL prescaler divides by 1 to 8, reset to 1.
// [R14] Feedback divider resets to 150; software keeps it within 16 to 200.
// [R15] Trim field is a signed offset, zero is centre frequency.
// [R16] VCO output ratio 11 undivided, 10 by 2, 01 by 3, 00 by 4.
// [R17] Software keeps output ratios 1 to 7 with first at least second.
// [R18] Software leaves output ratios alone while the PLL runs.
// [R19] Output ratios reset to 4 and 1.
// [R20] Unimplemented and reserved bits read as zero.
// [R21] Source fields share one encoding; reserved code falls back to fast RC.
// [R22] Request stays 1 during a switch; current source updates on completion.
module pcc_core
  import pcc_pkg::*;
#(
  parameter pcc_src_t POR_SOURCE   = SRC_FAST_RC_DIV,
  parameter int       START_CYCLES = PLL_START_CYCLES
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Register bus.
  input  wire pcc_axi_req_t axi_req,
  output pcc_axi_rsp_t      axi_rsp,
  // Clock system status, asynchronous.
  input  wire logic         pll_lock_in,
  input  wire logic         clock_fail_in,
  input  wire logic         switch_ack_in,
  // Interrupt event from the same clock domain.
  input  wire logic         irq_in,
  // Decoded configuration and trap.
  output pcc_cfg_t          cfg,
  output logic              osc_fail_trap
);

  generate
    // The start-up counter is sixteen bits wide, which bounds the start-up time.
    if (START_CYCLES < 1 || START_CYCLES > 65535) begin : g_bad_start
      $error("START_CYCLES out of range");
    end

    // No clock stands behind the reserved code, so reset must not select it.
    if (POR_SOURCE == SRC_RESERVED) begin : g_bad_por
      $error("POR_SOURCE is the reserved code");
    end
  endgenerate

  // All state is one struct, so reset and update each stay in one place.
  typedef struct packed {
    logic                 lock_s1;
    logic                 lock_s2;
    logic                 fail_s1;
    logic                 fail_s2;
    logic                 fail_s3;
    logic                 ack_s1;
    logic                 ack_s2;
    pcc_src_t             cur_src;
    pcc_src_t             next_sel;
    pcc_src_t             target;
    pcc_sw_t              sw_state;
    logic                 fail_flag;
    logic                 lock_flag;
    logic [PLL_CNT_W-1:0] pll_cnt;
    logic                 timer_done;
    logic [1:0]           unlock_stage;
    logic                 recover_on_irq;
    logic [2:0]           reduce;
    logic                 reduce_en;
    logic [2:0]           rc_post;
    logic [3:0]           prescale;
    logic [7:0]           feedback;
    logic [5:0]           trim;
    logic [1:0]           vco;
    logic [2:0]           post1;
    logic [2:0]           post2;
    logic                 aw_held;
    logic [PCC_AW-1:0]    aw_addr;
    logic                 w_held;
    logic [15:0]          w_data;
    logic [1:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 trap;
    pcc_cfg_t             cfg;
  } pcc_state_t;

  // The source starts from a parameter that stands in for configuration bits.
  localparam pcc_state_t RESET_STATE = '{
    cur_src:  POR_SOURCE,
    next_sel: POR_SOURCE,
    target:   POR_SOURCE,
    sw_state: SW_IDLE,
    reduce:   REDUCE_RST,
    rc_post:  RCPOST_RST,
    prescale: PRE_RST,
    feedback: FBD_RST,
    trim:     TRIM_RST,
    vco:      VCO_RST,
    post1:    P1_RST,
    post2:    P2_RST,
    cfg:      '{source: POR_SOURCE, switch_target: POR_SOURCE, cpu_div_log2: 3'h0,
                rc_div_log2: 4'h0, pll_prescale: PRE_RST, pll_feedback: FBD_RST,
                rc_trim: TRIM_RST, vco_div: 3'h4, first_ratio: P1_RST,
                second_ratio: P2_RST, switch_go: 1'b0},
    default:  '0
  };

  pcc_state_t s;
  pcc_state_t next_s;

  // Readback of one register; bit 16 marks a mapped address.
  // Unmapped addresses answer zero with the flag low, which becomes an error.
  function automatic logic [16:0] read_word(input pcc_state_t st, input logic [PCC_AW-1:0] a);
    logic [15:0] v;
    logic        hit;
    v   = '0; // [R20]
    hit = 1'b1;
    case (a)
      OFF_OSC_CTRL: begin
        v[OSC_CUR_LSB +: 3]  = st.cur_src;
        v[OSC_NEXT_LSB +: 3] = st.next_sel;
        v[OSC_LOCK_BIT]      = st.lock_flag;
        v[OSC_FAIL_BIT]      = st.fail_flag;
        v[OSC_SWREQ_BIT]     = (st.sw_state == SW_BUSY); // [R22]
      end
      OFF_CLK_DIV: begin
        v[DIV_ROI_BIT]          = st.recover_on_irq;
        v[DIV_REDUCE_LSB +: 3]  = st.reduce;
        v[DIV_RDEN_BIT]         = st.reduce_en;
        v[DIV_RCPOST_LSB +: 3]  = st.rc_post;
        v[DIV_PRE_LSB +: 4]     = st.prescale;
      end
      OFF_PLL_FBD:  v[7:0] = st.feedback;
      OFF_RC_TRIM:  v[5:0] = st.trim;
      OFF_PLL_ODIV: begin
        v[ODIV_VCO_LSB +: 2] = st.vco;
        v[ODIV_P1_LSB +: 3]  = st.post1;
        v[ODIV_P2_LSB +: 3]  = st.post2;
      end
      OFF_UNLOCK:   v = '0;
      default:      hit = 1'b0;
    endcase
    return {hit, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshakes are combinational from held state.
  // Reads and writes run apart, so a read never waits behind a write response.
  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = !s.aw_held && !s.bvalid;
    axi_rsp.wready  = !s.w_held && !s.bvalid;
    axi_rsp.bvalid  = s.bvalid;
    axi_rsp.bresp   = s.bresp;
    axi_rsp.arready = !s.rvalid;
    axi_rsp.rvalid  = s.rvalid;
    axi_rsp.rdata   = s.rdata;
    axi_rsp.rresp   = s.rresp;
  end

  assign cfg           = s.cfg;
  assign osc_fail_trap = s.trap;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [16:0] rd;
    logic [15:0] wv;
    logic [2:0]  red_new;
    pcc_src_t    sel_new;
    logic        pll_on;
    rd      = '0;
    wv      = '0;
    red_new = '0;
    sel_new = SRC_FAST_RC;
    pll_on  = 1'b0;
    next_s  = s;
    next_s.trap = 1'b0;

    // Two flops on each asynchronous pin; logic reads only the second.
    // The third fail flop only marks the rising edge.
    next_s.lock_s1 = pll_lock_in;
    next_s.lock_s2 = s.lock_s1;
    next_s.fail_s1 = clock_fail_in;
    next_s.fail_s2 = s.fail_s1;
    next_s.fail_s3 = s.fail_s2;
    next_s.ack_s1  = switch_ack_in;
    next_s.ack_s2  = s.ack_s1;

    // Address and data channels are taken independently.
    if (axi_req.awvalid && axi_rsp.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = axi_req.wdata[15:0];
      next_s.w_strb = axi_req.wstrb[1:0];
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are held.
    // Unstrobed lanes keep their value, so the old word is merged first.
    if (s.aw_held && s.w_held && !s.bvalid) begin
      rd = read_word(s, s.aw_addr);
      wv = rd[15:0];
      if (s.w_strb[0]) begin
        wv[7:0] = s.w_data[7:0];
      end
      if (s.w_strb[1]) begin
        wv[15:8] = s.w_data[15:8];
      end
      next_s.aw_held      = 1'b0;
      next_s.w_held       = 1'b0;
      next_s.bvalid       = 1'b1;
      next_s.bresp        = rd[16] ? RESP_OKAY : RESP_SLVERR;
      next_s.unlock_stage = 2'h0;

      // Any write but the next expected key disarms the unlock, so a stray
      // write cannot leave the oscillator control register open.
      case (s.aw_addr)
        OFF_UNLOCK: begin
          if (s.unlock_stage == 2'h0 && s.w_data == UNLOCK_KEY_FIRST) begin
            next_s.unlock_stage = 2'h1;
          end else if (s.unlock_stage == 2'h1 && s.w_data == UNLOCK_KEY_SECOND) begin
            next_s.unlock_stage = 2'h2;
          end
        end
        OFF_OSC_CTRL: begin
          if (s.unlock_stage == 2'h2) begin // [R05]
            sel_new         = pcc_src_t'(wv[OSC_NEXT_LSB +: 3]);
            next_s.next_sel = sel_new;
            // Only a rising flag traps, so rewriting a set flag does not trap twice.
            // A monitor event in the same cycle beats a clear, further down.
            if (wv[OSC_FAIL_BIT] && !s.fail_flag) begin
              next_s.fail_flag = 1'b1; // [R03]
              next_s.trap      = 1'b1; // [R03]
            end else if (!wv[OSC_FAIL_BIT]) begin
              next_s.fail_flag = 1'b0;
            end
            if (wv[OSC_SWREQ_BIT] && s.sw_state == SW_IDLE) begin
              next_s.sw_state = SW_BUSY; // [R04]
              next_s.target   = (sel_new == SRC_RESERVED) ? SRC_FAST_RC : sel_new; // [R21]
            end
          end
        end
        OFF_CLK_DIV: begin
          next_s.recover_on_irq      = wv[DIV_ROI_BIT];
          next_s.rc_post  = wv[DIV_RCPOST_LSB +: 3];
          next_s.prescale = wv[DIV_PRE_LSB +: 4]; // [R13]

          // The enable is judged against the field as it will stand, so one write
          // cannot raise the enable over a zero field.
          red_new = s.reduce_en ? s.reduce : wv[DIV_REDUCE_LSB +: 3]; // [R10]
          next_s.reduce    = red_new;
          next_s.reduce_en = wv[DIV_RDEN_BIT] && (red_new != 3'h0); // [R11]
        end
        OFF_PLL_FBD:  next_s.feedback = wv[7:0]; // [R14]
        OFF_RC_TRIM:  next_s.trim = wv[5:0];
        OFF_PLL_ODIV: begin
          next_s.vco   = wv[ODIV_VCO_LSB +: 2];
          next_s.post1 = wv[ODIV_P1_LSB +: 3];
          next_s.post2 = wv[ODIV_P2_LSB +: 3];
        end
        default: begin
        end
      endcase
    end

    // Register read.
    // Read data is registered, so it stands unchanged until the master takes it.
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      rd            = read_word(s, axi_req.araddr);
      next_s.rvalid = 1'b1;
      next_s.rdata  = {16'h0000, rd[15:0]};
      next_s.rresp  = rd[16] ? RESP_OKAY : RESP_SLVERR;
    end

    // Hardware events come last so that they win over a software write in the same cycle.
    if (s.fail_s2 && !s.fail_s3) begin
      next_s.fail_flag = 1'b1; // [R02]
      next_s.trap      = 1'b1;
    end
    if (s.recover_on_irq && irq_in) begin
      next_s.reduce_en = 1'b0; // [R07]
    end

    // Switch sequencer: hold the request until the mux acknowledges.
    // Waiting for the acknowledge to fall keeps a new request from being
    // completed by the acknowledge of the switch before it.
    case (s.sw_state)
      SW_IDLE: begin
      end
      SW_BUSY: begin
        if (s.ack_s2) begin
          next_s.cur_src  = s.target; // [R22]
          next_s.sw_state = SW_DRAIN; // [R04]
        end
      end
      SW_DRAIN: begin
        if (!s.ack_s2) begin
          next_s.sw_state = SW_IDLE;
        end
      end
      default: next_s.sw_state = SW_IDLE;
    endcase

    // PLL start-up timer restarts whenever the PLL leaves service.
    // The lock pin is trusted only while a PLL source runs; the counter then
    // holds at its end value until a source without the PLL is selected.
    pll_on = (s.cur_src == SRC_FAST_RC_PLL) || (s.cur_src == SRC_PRIMARY_PLL);
    if (!pll_on) begin
      next_s.pll_cnt    = '0;
      next_s.timer_done = 1'b0;
    end else if (!s.timer_done) begin
      next_s.pll_cnt = s.pll_cnt + 1'b1;
      if (s.pll_cnt == PLL_CNT_W'(START_CYCLES - 1)) begin
        next_s.timer_done = 1'b1;
      end
    end
    next_s.lock_flag = pll_on && (s.lock_s2 || s.timer_done); // [R01]

    // Decoded configuration for the clock tree.
    // Decoding from the next state keeps these outputs in step with the
    // registers instead of a cycle behind them.
    next_s.cfg.source        = next_s.cur_src;
    next_s.cfg.switch_go     = (next_s.sw_state == SW_BUSY);
    next_s.cfg.switch_target = next_s.target;
    next_s.cfg.cpu_div_log2  = next_s.reduce_en ? next_s.reduce : 3'h0; // [R08] [R09]
    next_s.cfg.rc_div_log2   = (next_s.rc_post == 3'h7) ? 4'h8 : {1'b0, next_s.rc_post}; // [R12]
    next_s.cfg.pll_prescale  = next_s.prescale; // [R13]
    next_s.cfg.pll_feedback  = next_s.feedback;
    next_s.cfg.rc_trim       = next_s.trim; // [R15]
    next_s.cfg.vco_div       = 3'h4 - {1'b0, next_s.vco}; // [R16]
    next_s.cfg.first_ratio   = next_s.post1;
    next_s.cfg.second_ratio  = next_s.post2;
  end

  // Reset loads the power-on register values, including ratios 4 and 1.
  // Answers and flags start low, so nothing is pending after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= RESET_STATE; // [R19] [R14]
    end else begin
      s <= next_s;
    end
  end

endmodule

// file: pkg/pcc_pkg.sv
/*
  Shared constants and types for the primary core clock generator control block:
  register offsets, field positions, reset values, source codes, bus carriers.
  Assumes a 32-bit AXI4-Lite master with byte addressing and a 125 MHz system clock.
*/
package pcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry and answers.
  localparam int         PCC_AW      = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets.
  localparam logic [PCC_AW-1:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [PCC_AW-1:0] OFF_CLK_DIV  = 8'h04;
  localparam logic [PCC_AW-1:0] OFF_PLL_FBD  = 8'h08;
  localparam logic [PCC_AW-1:0] OFF_RC_TRIM  = 8'h0C;
  localparam logic [PCC_AW-1:0] OFF_PLL_ODIV = 8'h10;
  localparam logic [PCC_AW-1:0] OFF_UNLOCK   = 8'h14;

  // Unlock keys, written in this order to the unlock register.
  localparam logic [15:0] UNLOCK_KEY_FIRST  = 16'h00A5;
  localparam logic [15:0] UNLOCK_KEY_SECOND = 16'h005A;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int OSC_CUR_LSB    = 12;
  localparam int OSC_NEXT_LSB   = 8;
  localparam int OSC_LOCK_BIT   = 5;
  localparam int OSC_FAIL_BIT   = 3;
  localparam int OSC_SWREQ_BIT  = 0;
  localparam int DIV_ROI_BIT    = 15;
  localparam int DIV_REDUCE_LSB = 12;
  localparam int DIV_RDEN_BIT   = 11;
  localparam int DIV_RCPOST_LSB = 8;
  localparam int DIV_PRE_LSB    = 0;
  localparam int ODIV_VCO_LSB   = 8;
  localparam int ODIV_P1_LSB    = 4;
  localparam int ODIV_P2_LSB    = 0;

  // Values after reset.
  localparam logic [2:0] REDUCE_RST = 3'h3;
  localparam logic [2:0] RCPOST_RST = 3'h0;
  localparam logic [3:0] PRE_RST    = 4'h1;
  localparam logic [7:0] FBD_RST    = 8'h96;
  localparam logic [5:0] TRIM_RST   = 6'h00;
  localparam logic [1:0] VCO_RST    = 2'h0;
  localparam logic [2:0] P1_RST     = 3'h4;
  localparam logic [2:0] P2_RST     = 3'h1;

  // PLL start-up timer: a least time, rounded up to whole cycles.
  localparam int CLK_PERIOD_NS    = 8;
  localparam int PLL_START_NS     = 2000;
  localparam int PLL_START_CYCLES = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_CNT_W        = 16;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    SRC_FAST_RC      = 3'h0,
    SRC_FAST_RC_PLL  = 3'h1,
    SRC_PRIMARY      = 3'h2,
    SRC_PRIMARY_PLL  = 3'h3,
    SRC_RESERVED     = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_BACKUP_RC    = 3'h6,
    SRC_FAST_RC_DIV  = 3'h7
  } pcc_src_t;

  typedef enum logic [2:0] {
    SW_IDLE  = 3'h1,
    SW_BUSY  = 3'h2,
    SW_DRAIN = 3'h4
  } pcc_sw_t;

  typedef struct packed {
    logic              awvalid;
    logic [PCC_AW-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [PCC_AW-1:0] araddr;
    logic              rready;
  } pcc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcc_axi_rsp_t;

  typedef struct packed {
    pcc_src_t    source;
    logic        switch_go;
    pcc_src_t    switch_target;
    logic [2:0]  cpu_div_log2;
    logic [3:0]  rc_div_log2;
    logic [3:0]  pll_prescale;
    logic [7:0]  pll_feedback;
    logic [5:0]  rc_trim;
    logic [2:0]  vco_div;
    logic [2:0]  first_ratio;
    logic [2:0]  second_ratio;
  } pcc_cfg_t;

endpackage

// file: verif/pcc_checker.sv
/*
  Concurrent checks on the ports of pcc_core, bound to every instance below.
  Assumes the single clk domain with the asynchronous active-high rst.
*/
module pcc_checker
  import pcc_pkg::*;
#(
  parameter int START_CYCLES = PLL_START_CYCLES
) (
  // Clock and reset.
  input wire logic         clk,
  input wire logic         rst,
  // Bus and clock system status.
  input wire pcc_axi_req_t axi_req,
  input wire pcc_axi_rsp_t axi_rsp,
  input wire logic         pll_lock_in,
  input wire logic         clock_fail_in,
  input wire logic         switch_ack_in,
  input wire logic         irq_in,
  // Decoded configuration and trap.
  input wire pcc_cfg_t     cfg,
  input wire logic         osc_fail_trap
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_trap_one_pulse: assert property (osc_fail_trap |=> !osc_fail_trap)
    else $error("trap pulse longer than one cycle");
  a_fail_to_trap: assert property ($rose(clock_fail_in) |-> ##[1:6] osc_fail_trap)
    else $error("clock failure raised no trap");
  a_go_holds: assert property (cfg.switch_go && !switch_ack_in |=> cfg.switch_go)
    else $error("switch dropped without completion");
  a_ack_completes: assert property ($rose(switch_ack_in) && cfg.switch_go
    |-> ##[1:5] !cfg.switch_go)
    else $error("switch did not complete after acknowledge");
  a_source_on_done: assert property ($fell(cfg.switch_go) |-> cfg.source == cfg.switch_target)
    else $error("current source not updated at completion");
  a_source_only_switch: assert property (!$stable(cfg.source) |-> $past(cfg.switch_go))
    else $error("current source changed outside a switch");
  a_target_no_reserved: assert property (cfg.switch_go |-> cfg.switch_target != SRC_RESERVED)
    else $error("reserved source code used as target");
  a_read_upper_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_vco_ratio_legal: assert property (cfg.vco_div inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("vco divisor out of range");
  a_reduce_kept: assert property ($past(cfg.cpu_div_log2) != 3'h0 && !$stable(cfg.cpu_div_log2)
    |-> cfg.cpu_div_log2 == 3'h0)
    else $error("reduction changed while enabled");
endmodule

bind pcc_core pcc_checker #(.START_CYCLES(START_CYCLES)) pcc_checker_inst (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .pll_lock_in(pll_lock_in),
  .clock_fail_in(clock_fail_in), .switch_ack_in(switch_ack_in), .irq_in(irq_in),
  .cfg(cfg), .osc_fail_trap(osc_fail_trap));

// file: verif/tb.sv
/*
  Self-checking bench for pcc_core: register table rows, then divider, switch,
  unlock, fail and reset cases. Assumes the design answers on AXI4-Lite at 125 MHz.
*/
module tb
  import pcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0]  r;
  } pcc_row_t;
  logic         clk;
  logic         rst;
  pcc_axi_req_t req;
  pcc_axi_rsp_t rsp;
  logic         lock;
  logic         fail;
  logic         ack;
  logic         irq;
  pcc_cfg_t     cfg;
  logic         trap;
  int           err_total;
  int           checked;
  int           trap_cnt;
  logic [31:0]  rdat;
  logic [1:0]   rr;
  pcc_row_t     rows [11] = '{
    {OFF_CLK_DIV, 1'b0, 16'h0000, 16'h3001, RESP_OKAY},
    {OFF_PLL_FBD, 1'b0, 16'h0000, 16'h0096, RESP_OKAY},
    {OFF_RC_TRIM, 1'b0, 16'h0000, 16'h0000, RESP_OKAY},
    {OFF_PLL_ODIV, 1'b0, 16'h0000, 16'h0041, RESP_OKAY},
    {OFF_OSC_CTRL, 1'b0, 16'h0000, 16'h7700, RESP_OKAY},
    {OFF_PLL_FBD, 1'b1, 16'hFFC8, 16'h00C8, RESP_OKAY},
    {OFF_RC_TRIM, 1'b1, 16'hFFE0, 16'h0020, RESP_OKAY},
    {OFF_PLL_ODIV, 1'b1, 16'hFF77, 16'h0377, RESP_OKAY},
    {OFF_CLK_DIV, 1'b1, 16'hF7F8, 16'hF708, RESP_OKAY},
    {OFF_UNLOCK, 1'b0, 16'h0000, 16'h0000, RESP_OKAY},
    {8'h18, 1'b1, 16'h1234, 16'h0000, RESP_SLVERR}};

  pcc_core #(.START_CYCLES(4)) pcc_core_inst (
    .clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .pll_lock_in(lock),
    .clock_fail_in(fail), .switch_ack_in(ack), .irq_in(irq), .cfg(cfg), .osc_fail_trap(trap));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // The trap is a one-cycle pulse, so it is counted rather than sampled.
  always @(negedge clk) begin
    if (trap === 1'b1) trap_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic tmo();
    err_total++;
    $display("MISMATCH handshake expected answer seen none");
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic af, wf, bf;
    logic [1:0] br;
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= {16'h0000, d};
    req.wstrb   <= 4'hF;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      af = req.awvalid & rsp.awready;
      wf = req.wvalid & rsp.wready;
      bf = rsp.bvalid;
      br = rsp.bresp;
      @(posedge clk);
      if (af === 1'b1) req.awvalid <= 1'b0;
      if (wf === 1'b1) req.wvalid <= 1'b0;
      if (bf === 1'b1) begin
        req.bready <= 1'b0;
        chk("bresp", 32'(er), 32'(br));
        repeat (2) @(posedge clk);
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic af, rf;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      af = req.arvalid & rsp.arready;
      rf = rsp.rvalid;
      rdat = rsp.rdata;
      rr = rsp.rresp;
      @(posedge clk);
      if (af === 1'b1) req.arvalid <= 1'b0;
      if (rf === 1'b1) begin
        req.rready <= 1'b0;
        chk("rresp", 32'(er), 32'(rr));
        @(posedge clk);
        return;
      end
    end
    tmo();
  endtask
  task automatic unlock();
    wr(OFF_UNLOCK, UNLOCK_KEY_FIRST, RESP_OKAY);
    wr(OFF_UNLOCK, UNLOCK_KEY_SECOND, RESP_OKAY);
  endtask
  task automatic sw(input logic [2:0] code);
    unlock();
    wr(OFF_OSC_CTRL, {5'h00, code, 8'h01}, RESP_OKAY);
    chk("switch_go", 1, cfg.switch_go);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("req_bit_busy", 1, rdat[0]);
    ack <= 1'b1;
    for (int n = 0; n <= 20; n++) begin
      @(negedge clk);
      if (cfg.switch_go === 1'b0) break;
      if (n == 20) tmo();
    end
    @(posedge clk);
    ack <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse_irq();
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    req = '0;
    lock = 1'b1;
    fail = 1'b0;
    ack = 1'b0;
    irq = 1'b0;
    err_total = 0;
    checked = 0;
    trap_cnt = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rows[i].r);
      chk("register", {16'h0000, rows[i].e}, rdat);
    end
    chk("prescale", 8, cfg.pll_prescale);
    chk("feedback", 32'h00C8, cfg.pll_feedback);
    chk("trim", 32'h0020, cfg.rc_trim);
    chk("ratios", 32'h0077, {cfg.first_ratio, 1'b0, cfg.second_ratio});
    $display("test register table done");
    for (int i = 0; i < 4; i++) begin
      wr(OFF_PLL_ODIV, {6'h00, i[1:0], 8'h41}, RESP_OKAY);
      chk("vco_div", 4 - i, cfg.vco_div);
    end
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CLK_DIV, {5'h06, i[2:0], 8'h01}, RESP_OKAY);
      chk("rc_div", (i == 7) ? 8 : i, cfg.rc_div_log2);
    end
    for (int d = 1; d < 8; d++) begin
      repeat (2) wr(OFF_CLK_DIV, {1'b0, d[2:0], 12'h001}, RESP_OKAY);
      chk("cpu_div_off", 0, cfg.cpu_div_log2);
      wr(OFF_CLK_DIV, {1'b0, d[2:0], 12'h801}, RESP_OKAY);
      chk("cpu_div_on", d, cfg.cpu_div_log2);
    end
    wr(OFF_CLK_DIV, {4'h2, 12'h801}, RESP_OKAY);
    chk("cpu_div_kept", 7, cfg.cpu_div_log2);
    wr(OFF_CLK_DIV, {4'hF, 12'h801}, RESP_OKAY);
    pulse_irq();
    chk("irq_recover", 0, cfg.cpu_div_log2);
    wr(OFF_CLK_DIV, {4'h7, 12'h801}, RESP_OKAY);
    pulse_irq();
    chk("irq_ignored", 7, cfg.cpu_div_log2);
    repeat (2) wr(OFF_CLK_DIV, 16'h0001, RESP_OKAY);
    wr(OFF_CLK_DIV, 16'h0801, RESP_OKAY);
    rd(OFF_CLK_DIV, RESP_OKAY);
    chk("enable_refused", 32'h0001, rdat);
    $display("test dividers done");
    wr(OFF_OSC_CTRL, 16'h0101, RESP_OKAY);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("locked_write", 32'h7700, rdat);
    sw(3'h1);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("osc_after_sw1", 32'h1120, rdat);
    lock <= 1'b0;
    sw(3'h4);
    chk("reserved_src", 32'(SRC_FAST_RC), 32'(cfg.source));
    sw(3'h3);
    repeat (10) @(posedge clk);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("osc_after_sw3", 32'h3320, rdat);
    $display("test switching done");
    unlock();
    wr(OFF_OSC_CTRL, 16'h0308, RESP_OKAY);
    chk("trap_sw", 1, trap_cnt);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("fail_sw", 1, rdat[3]);
    unlock();
    wr(OFF_OSC_CTRL, 16'h0300, RESP_OKAY);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("fail_clear", 0, rdat[3]);
    fail <= 1'b1;
    repeat (8) @(posedge clk);
    chk("trap_hw", 2, trap_cnt);
    rd(OFF_OSC_CTRL, RESP_OKAY);
    chk("fail_hw", 1, rdat[3]);
    fail <= 1'b0;
    $display("test clock fail done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CLK_DIV, RESP_OKAY);
    chk("reset_div", 32'h3001, rdat);
    chk("reset_src", 32'(SRC_FAST_RC_DIV), 32'(cfg.source));
    chk("reset_ratios", 32'h0041, {cfg.first_ratio, 1'b0, cfg.second_ratio});
    chk("reset_vco", 4, cfg.vco_div);
    $display("test second reset done");
    results();
  end
endmodule
